//--- hdl/fsr_defines.vh
// constants shared by the flash status register block
`ifndef FSR_DEFINES_VH
`define FSR_DEFINES_VH

// command opcodes
`define FSR_OP_RD_STATUS   8'h05
`define FSR_OP_ACT_STATUS  8'h25
`define FSR_OP_WR_ENABLE   8'h06
`define FSR_OP_WR_DISABLE  8'h04
`define FSR_OP_WR_STAT1    8'h01
`define FSR_OP_WR_STAT2    8'h31
`define FSR_OP_PROT_SECT   8'h36
`define FSR_OP_UNPROT_SECT 8'h39
`define FSR_OP_PROGRAM     8'h02
`define FSR_OP_SEQ_PROG    8'hac
`define FSR_OP_ERASE_4K    8'h20
`define FSR_OP_ERASE_32K   8'h52
`define FSR_OP_ERASE_64K   8'hd8
`define FSR_OP_ERASE_CHIP  8'h60
`define FSR_OP_ERASE_CHIP2 8'hc7
`define FSR_OP_SOFT_RESET  8'hf0

// serial bit counts
`define FSR_BITS_OPCODE    6'd8
`define FSR_BITS_ONE_DATA  6'd16
`define FSR_BITS_ADDR      6'd32
`define FSR_CNT_MAX        6'h3f
`define FSR_OPCODE_LAST    6'd7
`define FSR_DATA_LAST      6'd15

// status byte one field positions
`define FSR_S1_LOCK        7
`define FSR_S1_SEQ         6
`define FSR_S1_FAIL        5
`define FSR_S1_WPP         4
`define FSR_S1_SWP_HI      3
`define FSR_S1_SWP_LO      2
`define FSR_S1_WEL         1
`define FSR_S1_BUSY        0

// status byte two field positions
`define FSR_S2_RESET_CMD_ENABLE        4
`define FSR_S2_BUSY        0

// write-status data fields
`define FSR_WS_GLOBAL_HI   5
`define FSR_WS_GLOBAL_LO   2

// protection summary encodings
`define FSR_SWP_NONE       2'b00
`define FSR_SWP_SOME       2'b01
`define FSR_SWP_ALL        2'b11

// reset values
`define FSR_RST_BIT        1'b0
`define FSR_RST_BYTE       8'h00
`define FSR_RST_CNT        6'd0
`define FSR_RST_IDX        4'd0

`endif

//--- hdl/fsr_status_pack.v
// assembles both status bytes and the protection summary
`timescale 1ns/1ps
`include "fsr_defines.vh"
module fsr_status_pack #(
    parameter NSECT = 4                  // number of protectable sectors
) (
    input  wire [NSECT-1:0] sect_prot_i, // per-sector protect bits
    input  wire             lock_i,
    input  wire             seq_i,
    input  wire             fail_i,
    input  wire             wp_n_i,      // synchronised pin, high = released
    input  wire             wel_i,
    input  wire             busy_i,
    input  wire             reset_cmd_enable_i,
    output reg  [7:0]       byte_one_o,
    output reg  [7:0]       byte_two_o
);
    // per-sector and/or accumulation, one stage per entry
    wire [NSECT:0] any_chain;            // some sector protected
    wire [NSECT:0] all_chain;            // every sector protected
    assign any_chain[0] = 1'b0;
    assign all_chain[0] = 1'b1;
    genvar g;
    generate
        for (g = 0; g < NSECT; g = g + 1) begin : g_sect
            assign any_chain[g+1] = any_chain[g] | sect_prot_i[g];
            assign all_chain[g+1] = all_chain[g] & sect_prot_i[g];
        end
    endgenerate

    // summary encoding and byte layout; unused bits stay zero
    always @* begin
        byte_one_o = `FSR_RST_BYTE;
        byte_two_o = `FSR_RST_BYTE;
        byte_one_o[`FSR_S1_LOCK] = lock_i;
        byte_one_o[`FSR_S1_SEQ]  = seq_i;
        byte_one_o[`FSR_S1_FAIL] = fail_i;
        // pin level, set while pin released
        byte_one_o[`FSR_S1_WPP]  = wp_n_i;
        if (all_chain[NSECT]) begin
            byte_one_o[`FSR_S1_SWP_HI:`FSR_S1_SWP_LO] = `FSR_SWP_ALL;
        end else if (any_chain[NSECT]) begin
            byte_one_o[`FSR_S1_SWP_HI:`FSR_S1_SWP_LO] = `FSR_SWP_SOME;
        end else begin
            byte_one_o[`FSR_S1_SWP_HI:`FSR_S1_SWP_LO] = `FSR_SWP_NONE;
        end
        byte_one_o[`FSR_S1_WEL]  = wel_i;
        byte_one_o[`FSR_S1_BUSY] = busy_i;
        byte_two_o[`FSR_S2_RESET_CMD_ENABLE] = reset_cmd_enable_i;
        byte_two_o[`FSR_S2_BUSY] = busy_i;
    end
endmodule // fsr_status_pack

//--- hdl/fsr_status_top.v
// status registers, write latch and active status output of a serial flash
`timescale 1ns/1ps
`include "fsr_defines.vh"
module fsr_status_top #(
    parameter NSECT = 4                          // protectable sectors
) (
    input  wire             CLK_I,               // 50 MHz system clock
    input  wire             RESET_N_I,           // synchronous, active low
    input  wire             CS_N_I,              // chip select pin
    input  wire             SCK_I,               // serial clock pin
    input  wire             SI_I,                // serial data in pin
    input  wire             WP_N_I,              // write-protect pin
    output wire             SO_O,                // serial data out
    output wire             SO_OE_N_O,           // low while driving
    input  wire [NSECT-1:0] SECT_PROT_I,         // per-sector protect state
    input  wire             SEQ_ACTIVE_I,        // array in sequential mode
    input  wire             SEQ_END_I,           // sequential end or abort
    input  wire             HOLD_ABORT_I,        // hold condition abort
    input  wire             ARRAY_DONE_I,        // operation finished
    input  wire             ARRAY_FAIL_I,        // qualifies done: bad byte
    input  wire             ARRAY_ABORT_I,       // operation aborted
    output reg              ARRAY_REQ_O,         // start program or erase
    output reg  [7:0]       ARRAY_OP_O,          // opcode of that request
    output reg  [23:0]      ADDR_O,              // address of request
    output reg              PROT_SECTOR_O,       // protect sector pulse
    output reg              UNPROT_SECTOR_O,     // unprotect sector pulse
    output reg              GLOBAL_REQ_O,        // global protect/unprotect
    output reg  [3:0]       GLOBAL_BITS_O,       // global select bits
    output reg              SOFT_RESET_O,        // accepted reset command
    output wire [7:0]       STATUS1_O,           // status byte one
    output wire [7:0]       STATUS2_O            // status byte two
);
    // synchronised pins
    wire [3:0] pin_sync;                         // {wp_n, si, sck, cs_n}
    wire       cs_n_s = pin_sync[0];
    wire       sck_s  = pin_sync[1];
    wire       si_s   = pin_sync[2];
    wire       wp_n_s = pin_sync[3];

    // register state
    reg        lock_reg;                         // protection lock bit
    reg        seq_reg;                          // sequential mode flag
    reg        fail_reg;                         // program fail flag
    reg        wel_reg;                          // write latch bit
    reg        busy_reg;                         // busy flag
    reg        reset_cmd_enable_reg;                         // reset command enable
    // serial front end
    reg        sck_d_reg;                        // previous sck for edges
    reg        cs_act_d_reg;                     // previous chip select
    reg [31:0] shift_reg;                        // incoming bits
    reg [5:0]  cnt_reg;                          // bits since select
    reg [2:0]  phase_reg;                        // bit position in byte
    reg [7:0]  op_reg;                           // captured opcode
    reg [7:0]  data_reg;                         // first data byte
    reg [3:0]  idx_reg;                          // status stream position
    reg        so_reg;                           // output bit
    reg        drive_reg;                        // output enabled
    reg [2:0]  mode_reg;                         // output mode, one-hot

    localparam [2:0] M_IDLE = 3'b001;            // output released
    localparam [2:0] M_READ = 3'b010;            // status stream
    localparam [2:0] M_ACT  = 3'b100;            // active status

    wire [7:0] byte_one;
    wire [7:0] byte_two;
    wire [15:0] status_word = {byte_one, byte_two};

    // edges and frame events on the system clock
    wire cs_act   = ~cs_n_s;
    wire sck_rise = sck_s & ~sck_d_reg;
    wire sck_fall = ~sck_s & sck_d_reg;
    wire cs_end   = cs_act_d_reg & ~cs_act;
    wire [7:0] op_now = {shift_reg[6:0], si_s};  // opcode on its last bit
    wire wp_on    = ~wp_n_s;                     // pin asserted

    // a full opcode is needed before a command decoded at release can change the latch
    wire full_op  = (cnt_reg >= `FSR_BITS_OPCODE);
    wire has_data = (cnt_reg >= `FSR_BITS_ONE_DATA);
    wire has_addr = (cnt_reg >= `FSR_BITS_ADDR);
    wire on_byte  = (phase_reg == 3'd0);

    // array opcodes grouped once, shared by decode below
    wire is_prog  = (op_reg == `FSR_OP_PROGRAM) || (op_reg == `FSR_OP_SEQ_PROG);
    wire is_erase = (op_reg == `FSR_OP_ERASE_4K) || (op_reg == `FSR_OP_ERASE_32K)
                 || (op_reg == `FSR_OP_ERASE_64K);
    wire is_chip  = (op_reg == `FSR_OP_ERASE_CHIP) || (op_reg == `FSR_OP_ERASE_CHIP2);

    fsr_sync #(
        .WIDTH (4),
        .INIT  (4'b1001)
    ) u_sync (
        .clk_i     (CLK_I),
        .reset_n_i (RESET_N_I),
        .async_i   ({WP_N_I, SI_I, SCK_I, CS_N_I}),
        .sync_o    (pin_sync)
    );

    fsr_status_pack #(
        .NSECT (NSECT)
    ) u_pack (
        .sect_prot_i (SECT_PROT_I),
        .lock_i      (lock_reg),
        .seq_i       (seq_reg),
        .fail_i      (fail_reg),
        .wp_n_i      (wp_n_s),
        .wel_i       (wel_reg),
        .busy_i      (busy_reg),
        .reset_cmd_enable_i      (reset_cmd_enable_reg),
        .byte_one_o  (byte_one),
        .byte_two_o  (byte_two)
    );

    assign STATUS1_O = byte_one;
    assign STATUS2_O = byte_two;
    assign SO_O      = so_reg;
    assign SO_OE_N_O = ~drive_reg;

    // serial front end: shift on sck rise, status stream output on sck fall
    always @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            sck_d_reg    <= `FSR_RST_BIT;
            cs_act_d_reg <= `FSR_RST_BIT;
            shift_reg    <= 32'h0000_0000;
            cnt_reg      <= `FSR_RST_CNT;
            phase_reg    <= 3'd0;
            op_reg       <= `FSR_RST_BYTE;
            data_reg     <= `FSR_RST_BYTE;
            idx_reg      <= `FSR_RST_IDX;
            so_reg       <= `FSR_RST_BIT;
            drive_reg    <= `FSR_RST_BIT;
            mode_reg     <= M_IDLE;
        end else begin
            sck_d_reg    <= sck_s;
            cs_act_d_reg <= cs_act;
            if (!cs_act) begin
                // release ends any output, even mid-byte
                cnt_reg   <= `FSR_RST_CNT;
                phase_reg <= 3'd0;
                idx_reg   <= `FSR_RST_IDX;
                drive_reg <= 1'b0;
                mode_reg  <= M_IDLE;
                if (!cs_end) begin
                    op_reg <= `FSR_RST_BYTE;
                end
            end else begin
                if (sck_rise) begin
                    shift_reg <= {shift_reg[30:0], si_s};
                    phase_reg <= phase_reg + 3'd1;
                    // counter saturates; long tails are ignored
                    if (cnt_reg != `FSR_CNT_MAX) begin
                        cnt_reg <= cnt_reg + 6'd1;
                    end
                    if (cnt_reg == `FSR_OPCODE_LAST) begin
                        op_reg <= op_now;
                        // active status starts on its opcode
                        if (op_now == `FSR_OP_ACT_STATUS) begin
                            mode_reg  <= M_ACT;
                            so_reg    <= busy_reg;
                            drive_reg <= 1'b1;
                        end else if (op_now == `FSR_OP_RD_STATUS) begin
                            mode_reg <= M_READ;
                        end
                    end
                    // later input bits are don't care here
                    if (cnt_reg == `FSR_DATA_LAST) begin
                        data_reg <= op_now;
                    end
                end
                case (mode_reg)
                    M_READ: begin
                        // byte one then two, msb first, live data
                        if (sck_fall) begin
                            so_reg    <= status_word[4'd15 - idx_reg];
                            idx_reg   <= idx_reg + 4'd1;
                            drive_reg <= 1'b1;
                        end
                    end
                    M_ACT: begin
                        // may fall with busy, never rises
                        so_reg <= so_reg & busy_reg;
                    end
                    default: begin
                        // no hold here: it would undo the entry value set above
                    end
                endcase
            end
        end
    end

    // status bits, latch and command completion at chip select release
    always @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            lock_reg        <= `FSR_RST_BIT;
            seq_reg         <= `FSR_RST_BIT;
            fail_reg        <= `FSR_RST_BIT;
            wel_reg         <= `FSR_RST_BIT;
            busy_reg        <= `FSR_RST_BIT;
            reset_cmd_enable_reg        <= `FSR_RST_BIT;
            ARRAY_REQ_O     <= 1'b0;
            ARRAY_OP_O      <= `FSR_RST_BYTE;
            ADDR_O          <= 24'h00_0000;
            PROT_SECTOR_O   <= 1'b0;
            UNPROT_SECTOR_O <= 1'b0;
            GLOBAL_REQ_O    <= 1'b0;
            GLOBAL_BITS_O   <= 4'h0;
            SOFT_RESET_O    <= 1'b0;
        end else begin
            ARRAY_REQ_O     <= 1'b0;
            PROT_SECTOR_O   <= 1'b0;
            UNPROT_SECTOR_O <= 1'b0;
            GLOBAL_REQ_O    <= 1'b0;
            SOFT_RESET_O    <= 1'b0;
            seq_reg <= SEQ_ACTIVE_I;
            // busy ends only on finish or abort
            if (ARRAY_DONE_I) begin
                busy_reg <= 1'b0;
                fail_reg <= ARRAY_FAIL_I;
                wel_reg  <= 1'b0;
            end else if (ARRAY_ABORT_I) begin
                busy_reg <= 1'b0;
                fail_reg <= 1'b0;
                wel_reg  <= 1'b0;
            end
            // sequential end and hold abort clear latch
            if (SEQ_END_I || HOLD_ABORT_I) begin
                wel_reg <= 1'b0;
            end
            // later decode wins, so a new enable is not lost
            // partial opcode leaves latch untouched
            if (cs_end && full_op && !busy_reg) begin
                if (op_reg == `FSR_OP_WR_ENABLE) begin
                    wel_reg <= 1'b1;
                end else if (op_reg == `FSR_OP_WR_DISABLE) begin
                    wel_reg <= 1'b0;
                end else if (op_reg == `FSR_OP_WR_STAT1) begin
                    wel_reg <= 1'b0;
                    if (wel_reg && has_data
                        && !(wp_on && lock_reg && !data_reg[`FSR_S1_LOCK])) begin
                        // only the lock bit is written
                        lock_reg <= data_reg[`FSR_S1_LOCK];
                        // global action uses the prior lock
                        if (!lock_reg) begin
                            GLOBAL_REQ_O  <= 1'b1;
                            GLOBAL_BITS_O <= data_reg[`FSR_WS_GLOBAL_HI:`FSR_WS_GLOBAL_LO];
                        end
                    end
                end else if (op_reg == `FSR_OP_WR_STAT2) begin
                    wel_reg <= 1'b0;
                    if (wel_reg && has_data && on_byte) begin
                        reset_cmd_enable_reg <= data_reg[`FSR_S2_RESET_CMD_ENABLE];
                    end
                end else if ((op_reg == `FSR_OP_PROT_SECT)
                          || (op_reg == `FSR_OP_UNPROT_SECT)) begin
                    wel_reg <= 1'b0;
                    if (wel_reg && has_addr && !lock_reg) begin
                        PROT_SECTOR_O   <= (op_reg == `FSR_OP_PROT_SECT);
                        UNPROT_SECTOR_O <= (op_reg == `FSR_OP_UNPROT_SECT);
                        ADDR_O          <= shift_reg[23:0];
                    end
                end else if (is_prog || is_erase || is_chip) begin
                    if (wel_reg && (is_chip || has_addr)) begin
                        ARRAY_REQ_O <= 1'b1;
                        ARRAY_OP_O  <= op_reg;
                        ADDR_O      <= is_chip ? 24'h00_0000 : shift_reg[23:0];
                        busy_reg    <= 1'b1;
                    end else begin
                        wel_reg <= 1'b0;
                    end
                end else if (op_reg == `FSR_OP_SOFT_RESET) begin
                    if (reset_cmd_enable_reg) begin
                        SOFT_RESET_O <= 1'b1;
                        lock_reg     <= 1'b0;
                        wel_reg      <= 1'b0;
                        // an engine failure reported in this cycle still wins
                        fail_reg     <= ARRAY_DONE_I & ARRAY_FAIL_I;
                    end
                end
            end
        end
    end
endmodule // fsr_status_top

//--- hdl/fsr_sync.v
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module fsr_sync #(
    parameter WIDTH = 4,                 // number of pins
    parameter [WIDTH-1:0] INIT = 4'hf    // idle level of each pin
) (
    input  wire             clk_i,
    input  wire             reset_n_i,
    input  wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);
    // one two-stage chain per pin; first stage feeds only the second
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            reg meta_reg;                // first stage, read by second only
            reg stable_reg;              // second stage, safe to use
            always @(posedge clk_i) begin
                if (!reset_n_i) begin
                    meta_reg   <= INIT[g];
                    stable_reg <= INIT[g];
                end else begin
                    meta_reg   <= async_i[g];
                    stable_reg <= meta_reg;
                end
            end
            assign sync_o[g] = stable_reg;
        end
    endgenerate
endmodule // fsr_sync

//--- tb/flash_status_and_ready_signal_tb_top.sv
// self-checking bench for the flash status block
`timescale 1ns/1ps
module flash_status_and_ready_signal_tb_top;
    logic       CLK_I = 0, RESET_N_I = 0, WP_N_I = 1, SEQ_ACTIVE_I = 0, SEQ_END_I = 0;
    logic       HOLD_ABORT_I = 0, ARRAY_DONE_I = 0, ARRAY_FAIL_I = 0, ARRAY_ABORT_I = 0;
    logic [3:0] SECT_PROT_I = 4'h0;
    wire        CS_N_I, SCK_I, SI_I, SO_O, SO_OE_N_O, ARRAY_REQ_O, PROT_SECTOR_O;
    wire        UNPROT_SECTOR_O, GLOBAL_REQ_O, SOFT_RESET_O;
    wire [7:0]  ARRAY_OP_O, STATUS1_O, STATUS2_O;
    wire [23:0] ADDR_O;
    wire [3:0]  GLOBAL_BITS_O;
    int fail_count = 0, n_compared = 0, n_prot = 0, n_srst = 0, k;
    int n_unprot = 0, n_req = 0;
    int lock = 0, seq = 0, fail = 0, write_latch_bit = 0, busy = 0, reset_cmd_enable = 0; // model state
    logic [31:0] r;
    fsr_status_top dut (.CLK_I, .RESET_N_I, .CS_N_I, .SCK_I, .SI_I, .WP_N_I, .SO_O, .SO_OE_N_O,
        .SECT_PROT_I, .SEQ_ACTIVE_I, .SEQ_END_I, .HOLD_ABORT_I, .ARRAY_DONE_I, .ARRAY_FAIL_I,
        .ARRAY_ABORT_I, .ARRAY_REQ_O, .ARRAY_OP_O, .ADDR_O, .PROT_SECTOR_O, .UNPROT_SECTOR_O,
        .GLOBAL_REQ_O, .GLOBAL_BITS_O, .SOFT_RESET_O, .STATUS1_O, .STATUS2_O);
    fsr_host host (.clk_i(CLK_I), .so_i(SO_OE_N_O ? 1'bz : SO_O), .cs_n_o(CS_N_I),
        .sck_o(SCK_I), .si_o(SI_I));
    initial begin forever #10 CLK_I = ~CLK_I; end
    // pulse counters, one count per accepted command
    always @(posedge CLK_I) begin n_prot += PROT_SECTOR_O; n_srst += SOFT_RESET_O; end
    always @(posedge CLK_I) begin n_unprot += UNPROT_SECTOR_O; n_req += ARRAY_REQ_O; end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task end_sim;
        if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    function logic [1:0] soft_protect_summary(input logic [3:0] s);
        return &s ? 2'b11 : (|s ? 2'b01 : 2'b00);
    endfunction
    task cmd(input logic [7:0] op, input logic [31:0] d, input int n);
        host.xfer({op, d}, n, 0);
        repeat (6) @(negedge CLK_I);
    endtask
    task wen; cmd(8'h06, 32'h0, 8); write_latch_bit = 1; endtask
    // serial status stream against the model
    task rd_chk;
        cmd(8'h05, 32'h0, 24);
        chk("status", host.rd, {lock[0], seq[0], fail[0], WP_N_I, soft_protect_summary(SECT_PROT_I), write_latch_bit[0],
            busy[0], 3'b000, reset_cmd_enable[0], 3'b000, busy[0]});
    endtask
    initial begin
        r = $urandom(74);
        repeat (6) @(negedge CLK_I);
        RESET_N_I = 1;
        repeat (4) @(negedge CLK_I);
        rd_chk;
        cmd(8'h01, 32'h8000_0000, 16);
        rd_chk;
        r = $urandom;
        SEQ_ACTIVE_I = r[8];
        seq = r[8];
        wen;
        cmd(8'h01, {1'b1, r[6:0], 24'h0}, 16);
        lock = 1; write_latch_bit = 0;
        rd_chk;
        chk("global", GLOBAL_BITS_O, r[5:2]);
        WP_N_I = 0;
        wen;
        cmd(8'h01, 32'h0, 16);
        write_latch_bit = 0;
        rd_chk;
        wen;
        cmd(8'h36, r, 32);
        cmd(8'h04, 32'h0, 8);
        chk("prot", n_prot, 0);
        WP_N_I = 1;
        wen;
        cmd(8'h01, 32'h0, 16);
        lock = 0;
        wen;
        cmd(8'h36, r, 32);
        write_latch_bit = 0;
        chk("prot", n_prot, 1);
        wen;
        cmd(8'h39, r, 32);
        write_latch_bit = 0;
        chk("unprot", n_unprot, 1);
        wen;
        cmd(8'h02, 32'h0, 5);
        rd_chk;
        // program completes, erase aborts, both polled by active status
        for (k = 0; k < 2; k++) begin
            r = $urandom;
            wen;
            cmd(k ? 8'h20 : 8'h02, r, 32);
            busy = 1;
            chk("addr", ADDR_O, r[31:8]);
            chk("req", n_req, k + 1);
            chk("op", ARRAY_OP_O, k ? 8'h20 : 8'h02);
            rd_chk;
            host.xfer({8'h25, 32'h0}, 8, 1);
            repeat (8) @(negedge CLK_I);
            chk("active", {SO_OE_N_O, SO_O}, 2'b01);
            ARRAY_FAIL_I = r[0];
            {ARRAY_DONE_I, ARRAY_ABORT_I} = k ? 2'b01 : 2'b10;
            @(negedge CLK_I);
            {ARRAY_DONE_I, ARRAY_ABORT_I} = 2'b00;
            fail = k ? 0 : r[0]; busy = 0; write_latch_bit = 0;
            repeat (6) @(negedge CLK_I);
            chk("active", {SO_OE_N_O, SO_O}, 2'b00);
            host.cs_n_o = 1;
            repeat (8) @(negedge CLK_I);
            chk("release", SO_OE_N_O, 1'b1);
            rd_chk;
        end
        for (k = 0; k < 2; k++) begin
            wen;
            {SEQ_END_I, HOLD_ABORT_I} = k ? 2'b10 : 2'b01;
            @(negedge CLK_I);
            {SEQ_END_I, HOLD_ABORT_I} = 2'b00;
            write_latch_bit = 0;
            rd_chk;
        end
        cmd(8'h02, 32'h0, 32);
        chk("req", n_req, 2);
        cmd(8'hf0, 32'h0, 8);
        chk("reset cmd", n_srst, 0);
        wen;
        cmd(8'h31, 32'h1000_0000, 16);
        reset_cmd_enable = 1; write_latch_bit = 0;
        cmd(8'hf0, 32'h0, 8);
        chk("reset cmd", n_srst, 1);
        rd_chk;
        for (k = 0; k < 16; k++) begin
            SECT_PROT_I = 4'(k);
            repeat (4) @(negedge CLK_I);
            chk("summary", STATUS1_O[3:2], soft_protect_summary(4'(k)));
        end
        end_sim;
    end
    initial begin #1000000; fail_count++; end_sim; end
endmodule // flash_status_and_ready_signal_tb_top

//--- tb/fsr_host.sv
// spi host model standing at the far side of the flash pins
`timescale 1ns/1ps
module fsr_host (
    input  wire logic clk_i,
    input  wire logic so_i,
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      si_o
);
    logic [15:0] rd; // last sixteen bits seen on the output
    initial begin cs_n_o = 1; sck_o = 0; si_o = 0; rd = 0; end
    // mode 0 frame, msb first, no dummy bit; clock parks low between frames
    task xfer(input logic [39:0] b, input int n, input bit hold);
        int i;
        cs_n_o = 0;
        for (i = 0; i < n; i++) begin
            rd = {rd[14:0], so_i}; // sampled just before the falling edge
            sck_o = 0;
            si_o = b[39-i];
            repeat (4) @(negedge clk_i);
            sck_o = 1;
            repeat (4) @(negedge clk_i);
        end
        rd = {rd[14:0], so_i};
        sck_o = 0;
        // hold keeps select low for active status polling
        if (!hold) begin repeat (4) @(negedge clk_i); cs_n_o = 1; si_o = ~si_o; end
    endtask
endmodule // fsr_host

//--- tb/fsr_status_props.sv
// port assertions for the flash status block
`timescale 1ns/1ps
module fsr_status_props #(parameter NSECT = 4) (
    input wire logic             CLK_I,
    input wire logic             RESET_N_I,
    input wire logic             CS_N_I,
    input wire logic             WP_N_I,
    input wire logic             SO_OE_N_O,
    input wire logic [NSECT-1:0] SECT_PROT_I,
    input wire logic             ARRAY_DONE_I,
    input wire logic             ARRAY_FAIL_I,
    input wire logic             ARRAY_ABORT_I,
    input wire logic             PROT_SECTOR_O,
    input wire logic             GLOBAL_REQ_O,
    input wire logic [7:0]       STATUS1_O,
    input wire logic [7:0]       STATUS2_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    // summary code expected from the sector levels
    wire [1:0] swp_exp = &SECT_PROT_I ? 2'b11 : (|SECT_PROT_I ? 2'b01 : 2'b00);
    chk_reset_vals: assert property ($rose(RESET_N_I) |-> STATUS1_O[7:5] == 3'b000
        && STATUS1_O[1:0] == 2'b00 && STATUS2_O == 8'h00) else $error("reset values wrong");
    chk_byte_two: assert property (STATUS2_O[7:5] == 3'b000 && STATUS2_O[3:1] == 3'b000
        && STATUS2_O[0] == STATUS1_O[0]) else $error("byte two format wrong");
    chk_swp_code: assert property ($stable(SECT_PROT_I)[*3] |-> STATUS1_O[3:2] == swp_exp)
        else $error("summary code wrong");
    chk_wpp_mirror: assert property ($stable(WP_N_I)[*5] |-> STATUS1_O[4] == WP_N_I)
        else $error("pin state bit wrong");
    chk_fail_done: assert property (ARRAY_DONE_I |=> STATUS1_O[5] == $past(ARRAY_FAIL_I))
        else $error("fail flag not updated");
    chk_fail_abort: assert property (ARRAY_ABORT_I |=> !STATUS1_O[5])
        else $error("fail flag set on abort");
    chk_done_clears: assert property ((ARRAY_DONE_I || ARRAY_ABORT_I) |=> STATUS1_O[1:0] == 2'b00)
        else $error("latch or busy not cleared");
    chk_write_guard: assert property ((PROT_SECTOR_O || GLOBAL_REQ_O) |->
        $past(STATUS1_O[1]) && !$past(STATUS1_O[7])) else $error("protection while guarded");
    chk_so_release: assert property (CS_N_I[*6] |-> SO_OE_N_O)
        else $error("output driven while deselected");
endmodule // fsr_status_props
bind fsr_status_top fsr_status_props #(.NSECT(NSECT)) u_props (.CLK_I, .RESET_N_I, .CS_N_I,
    .WP_N_I, .SO_OE_N_O, .SECT_PROT_I, .ARRAY_DONE_I, .ARRAY_FAIL_I, .ARRAY_ABORT_I,
    .PROT_SECTOR_O, .GLOBAL_REQ_O, .STATUS1_O, .STATUS2_O);
